//--- rtl/mfc_regs.svh
// register map and field positions of the fault settings bank
// assumes a word-wide ahb-lite slave decoding the low address byte
`ifndef MFC_REGS_SVH
`define MFC_REGS_SVH

`define MFC_SETTINGS_ADDR 8'h94
`define MFC_IRQ_STAT_ADDR 8'h98
`define MFC_IRQ_MASK_ADDR 8'h9c
`define MFC_SETTINGS_RST  32'h0000_0000
`define MFC_IRQ_RST       2'h0
`define MFC_TRANS_ACT     1
`define MFC_ADDR_F        7:0

`define MFC_PARITY_BIT    31
`define MFC_ABN_EN_BIT    30
`define MFC_SYNC_EN_BIT   29
`define MFC_NOMTR_EN_BIT  28
`define MFC_ABN_THR_F     27:24
`define MFC_SYNC_CNT_F    23:21
`define MFC_NOMTR_THR_F   20:18
`define MFC_OV_MODE_BIT   17
`define MFC_UPPER_F       16:14
`define MFC_UV_MODE_BIT   13
`define MFC_LOWER_F       12:10
`define MFC_RETRY_F       9:7
`define MFC_FLOOR_F       6:4
`define MFC_JUMP_F        3:2
`define MFC_DUTY_F        1:0

`define MFC_EV_CFG        0
`define MFC_EV_BAD        1
`define MFC_NEV           2

`define MFC_ABN_STEP      12'h0fa
`define MFC_SYNC_BASE     4'h2
`define MFC_DUTY_BASE     5'h0a
`define MFC_DUTY_STEP     5'h05

`endif

//--- rtl/mfc_pkg.sv
// types shared by the fault settings bank modules
// assumes mfc_regs.svh is on the include path
`include "mfc_regs.svh"
package mfc_pkg;
	typedef struct packed {
		logic [31:0]          settings;
		logic [`MFC_NEV-1:0]  irq_stat;
		logic [`MFC_NEV-1:0]  irq_mask;
		logic                 dph_wr;
		logic [7:0]           dph_addr;
		logic [31:0]          rdata;
	} mfc_state_t;

	typedef struct packed {
		logic [11:0] abn_hz;
		logic [3:0]  sync_cnt;
		logic [8:0]  nomtr_100uv;
		logic [5:0]  upper_v;
		logic [3:0]  lower_v;
		logic [4:0]  retry;
		logic [5:0]  floor_half_hz;
		logic [3:0]  jump;
		logic [4:0]  duty_permil;
	} mfc_dec_t;
endpackage

//--- rtl/mfc_decode.sv
// turns the stored field codes into engineering values for the supervisor
// assumes settings_in is the register's next value, so outputs track it
`timescale 1ns/1ps
`default_nettype none
`include "mfc_regs.svh"
module mfc_decode
	import mfc_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic [31:0] settings_in,
	output var mfc_dec_t     dec_out
);
	mfc_dec_t dec_r;
	mfc_dec_t dec_nxt;

	// lookups kept as constants, not stored tables
	function automatic logic [8:0] nomtr_lut(input logic [2:0] c);
		logic [71:0] t;
		t = {9'd400, 9'd300, 9'd250, 9'd200, 9'd125, 9'd100, 9'd75, 9'd50};
		return t[c*9 +: 9];
	endfunction

	function automatic logic [5:0] upper_lut(input logic [2:0] c);
		logic [47:0] t;
		t = {6'd60, 6'd50, 6'd40, 6'd35, 6'd30, 6'd25, 6'd20, 6'd0};
		return t[c*6 +: 6];
	endfunction

	function automatic logic [3:0] lower_lut(input logic [2:0] c);
		logic [31:0] t;
		t = {4'd15, 4'd12, 4'd10, 4'd9, 4'd8, 4'd7, 4'd6, 4'd0};
		return t[c*4 +: 4];
	endfunction

	function automatic logic [4:0] retry_lut(input logic [2:0] c);
		logic [39:0] t;
		t = {5'd20, 5'd15, 5'd10, 5'd7, 5'd5, 5'd3, 5'd2, 5'd0};
		return t[c*5 +: 5];
	endfunction

	function automatic logic [5:0] floor_lut(input logic [2:0] c);
		logic [47:0] t;
		t = {6'd50, 6'd30, 6'd20, 6'd10, 6'd6, 6'd4, 6'd2, 6'd1};
		return t[c*6 +: 6];
	endfunction

	always_comb
	begin
		dec_nxt.abn_hz        = 12'({8'h0, settings_in[`MFC_ABN_THR_F]} + 12'h1)
			* `MFC_ABN_STEP;
		dec_nxt.sync_cnt      = {1'b0, settings_in[`MFC_SYNC_CNT_F]} + `MFC_SYNC_BASE;
		dec_nxt.nomtr_100uv   = nomtr_lut(settings_in[`MFC_NOMTR_THR_F]);
		dec_nxt.upper_v       = upper_lut(settings_in[`MFC_UPPER_F]);
		dec_nxt.lower_v       = lower_lut(settings_in[`MFC_LOWER_F]);
		dec_nxt.retry         = retry_lut(settings_in[`MFC_RETRY_F]);
		dec_nxt.floor_half_hz = floor_lut(settings_in[`MFC_FLOOR_F]);
		dec_nxt.jump          = {1'b0, settings_in[`MFC_JUMP_F], 1'b0} + 4'h2;
		dec_nxt.duty_permil   = `MFC_DUTY_BASE
			+ 5'(settings_in[`MFC_DUTY_F] * `MFC_DUTY_STEP);
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			dec_r <= '{abn_hz: 12'h0fa, sync_cnt: 4'h2, nomtr_100uv: 9'h032,
				upper_v: 6'h0, lower_v: 4'h0, retry: 5'h0,
				floor_half_hz: 6'h1, jump: 4'h2, duty_permil: 5'h0a};
		else
			dec_r <= dec_nxt;
	end

	assign dec_out = dec_r;
endmodule // mfc_decode
`default_nettype wire

//--- rtl/mfc_bank.sv
// fault supervision settings register with ahb-lite access and interrupt
// assumes a single ahb-lite master; zero wait states, always okay
`timescale 1ns/1ps
`default_nettype none
`include "mfc_regs.svh"
// Summary of operation
// - settings word at 0x94, zero after reset
// - bit 30 enables abnormal speed lock
// - bit 29 enables sync loss lock
// - bit 28 enables no motor lock
// - bits 27:24 give (n+1)*250 Hz
// - bits 23:21 give n+2 sync losses
// - bits 20:18 pick no motor sense voltage
// - bit 17 overvoltage latch or auto clear
// - bits 16:14 pick upper supply limit
// - bit 13 undervoltage latch or auto clear
// - bits 12:10 pick lower supply limit
// - bits 9:7 limit retry attempts
// - bits 6:4 pick lock floor speed
// - bits 3:2 give speed jump ratio
// - bits 1:0 give zero duty threshold
module mfc_bank
	import mfc_pkg::*;
(
	input  wire logic        CLK_IN,
	input  wire logic        RST_IN,
	input  wire logic        HSEL_IN,
	input  wire logic [31:0] HADDR_IN,
	input  wire logic [1:0]  HTRANS_IN,
	input  wire logic        HWRITE_IN,
	input  wire logic [2:0]  HSIZE_IN,
	input  wire logic        HREADY_IN,
	input  wire logic [31:0] HWDATA_IN,
	output logic      [31:0] HRDATA_OUT,
	output logic             HREADYOUT_OUT,
	output logic             HRESP_OUT,
	output logic             IRQ_OUT,
	output logic             PARITY_OUT,
	output logic             ABNORMAL_SPEED_LOCK_ENABLE_OUT,
	output logic             SYNC_LOSS_LOCK_ENABLE_OUT,
	output logic             NO_MOTOR_LOCK_ENABLE_OUT,
	output logic      [11:0] ABNORMAL_SPEED_THRESHOLD_HZ_OUT,
	output logic      [3:0]  SYNC_LOSS_COUNT_OUT,
	output logic      [8:0]  NO_MOTOR_CURRENT_THRESHOLD_100UV_OUT,
	output logic             OVERVOLTAGE_CLEAR_MODE_OUT,
	output logic      [5:0]  SUPPLY_UPPER_LIMIT_V_OUT,
	output logic             UNDERVOLTAGE_CLEAR_MODE_OUT,
	output logic      [3:0]  SUPPLY_LOWER_LIMIT_V_OUT,
	output logic      [4:0]  RETRY_LIMIT_OUT,
	output logic      [5:0]  LOCK_FLOOR_SPEED_HALF_HZ_OUT,
	output logic      [3:0]  SPEED_JUMP_RATIO_OUT,
	output logic      [4:0]  ZERO_SPEED_DUTY_THRESHOLD_PERMIL_OUT
);
	mfc_state_t s_r;
	mfc_state_t s_nxt;
	mfc_dec_t   dec;
	logic       addr_take;
	logic [`MFC_NEV-1:0] ev;
	logic [`MFC_NEV-1:0] clr;

	function automatic logic is_mapped(input logic [7:0] a);
		return (a == `MFC_SETTINGS_ADDR) || (a == `MFC_IRQ_STAT_ADDR)
			|| (a == `MFC_IRQ_MASK_ADDR);
	endfunction

	function automatic logic [31:0] rd_mux(input logic [7:0] a, input mfc_state_t s);
		logic [31:0] d;
		d = 32'h0;
		if (a == `MFC_SETTINGS_ADDR)
			d = s.settings;
		else if (a == `MFC_IRQ_STAT_ADDR)
			d[`MFC_NEV-1:0] = s.irq_stat;
		else if (a == `MFC_IRQ_MASK_ADDR)
			d[`MFC_NEV-1:0] = s.irq_mask;
		return d;
	endfunction

	// only the low byte is decoded, so the bank aliases every 256 bytes
	assign addr_take = HSEL_IN && HTRANS_IN[`MFC_TRANS_ACT] && HREADY_IN;

	always_comb
	begin
		s_nxt = s_r;
		ev    = '0;
		clr   = '0;
		// data phase of a write lands here
		if (s_r.dph_wr)
		begin
			unique case (s_r.dph_addr)
				`MFC_SETTINGS_ADDR:
				begin
					s_nxt.settings = HWDATA_IN;
					ev[`MFC_EV_CFG] = 1'b1;
				end
				`MFC_IRQ_STAT_ADDR:
					clr = HWDATA_IN[`MFC_NEV-1:0];
				`MFC_IRQ_MASK_ADDR:
					s_nxt.irq_mask = HWDATA_IN[`MFC_NEV-1:0];
				default:
					ev[`MFC_EV_BAD] = 1'b1;
			endcase
		end
		if (addr_take && !HWRITE_IN && !is_mapped(HADDR_IN[`MFC_ADDR_F]))
			ev[`MFC_EV_BAD] = 1'b1;
		// set wins over a clear in the same cycle
		s_nxt.irq_stat = (s_r.irq_stat & ~clr) | ev;
		s_nxt.dph_wr   = addr_take && HWRITE_IN;
		if (addr_take)
			s_nxt.dph_addr = HADDR_IN[`MFC_ADDR_F];
		// read data from next state, so a read right after a write sees it
		if (addr_take && !HWRITE_IN)
			s_nxt.rdata = rd_mux(HADDR_IN[`MFC_ADDR_F], s_nxt);
		else
			s_nxt.rdata = 32'h0;
	end

	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			s_r.settings <= `MFC_SETTINGS_RST;
			s_r.irq_stat <= `MFC_IRQ_RST;
			s_r.irq_mask <= `MFC_IRQ_RST;
			s_r.dph_wr   <= 1'b0;
			s_r.dph_addr <= 8'h00;
			s_r.rdata    <= 32'h0;
		end
		else
			s_r <= s_nxt;
	end

	mfc_decode u_decode (
		.clk_in      (CLK_IN),
		.rst_in      (RST_IN),
		.settings_in (s_nxt.settings),
		.dec_out     (dec)
	);

	assign HRDATA_OUT    = s_r.rdata;
	assign HREADYOUT_OUT = 1'b1;
	assign HRESP_OUT     = 1'b0;
	assign IRQ_OUT       = |(s_r.irq_stat & s_r.irq_mask);

	assign PARITY_OUT                     = s_r.settings[`MFC_PARITY_BIT];
	assign ABNORMAL_SPEED_LOCK_ENABLE_OUT = s_r.settings[`MFC_ABN_EN_BIT];
	assign SYNC_LOSS_LOCK_ENABLE_OUT      = s_r.settings[`MFC_SYNC_EN_BIT];
	assign NO_MOTOR_LOCK_ENABLE_OUT       = s_r.settings[`MFC_NOMTR_EN_BIT];
	assign OVERVOLTAGE_CLEAR_MODE_OUT     = s_r.settings[`MFC_OV_MODE_BIT];
	assign UNDERVOLTAGE_CLEAR_MODE_OUT    = s_r.settings[`MFC_UV_MODE_BIT];

	assign ABNORMAL_SPEED_THRESHOLD_HZ_OUT      = dec.abn_hz;
	assign SYNC_LOSS_COUNT_OUT                  = dec.sync_cnt;
	assign NO_MOTOR_CURRENT_THRESHOLD_100UV_OUT = dec.nomtr_100uv;
	assign SUPPLY_UPPER_LIMIT_V_OUT             = dec.upper_v;
	assign SUPPLY_LOWER_LIMIT_V_OUT             = dec.lower_v;
	assign RETRY_LIMIT_OUT                      = dec.retry;
	assign LOCK_FLOOR_SPEED_HALF_HZ_OUT         = dec.floor_half_hz;
	assign SPEED_JUMP_RATIO_OUT                 = dec.jump;
	assign ZERO_SPEED_DUTY_THRESHOLD_PERMIL_OUT = dec.duty_permil;

	logic set_wr;
	assign set_wr = s_r.dph_wr && (s_r.dph_addr == `MFC_SETTINGS_ADDR);

	reset_zero_a: assert property (
		@(posedge CLK_IN) $fell(RST_IN) |-> (s_r.settings == 32'h0) && !IRQ_OUT
	) else $error("settings not zero after reset");

	abn_enable_a: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		set_wr |=> ABNORMAL_SPEED_LOCK_ENABLE_OUT == $past(HWDATA_IN[30])
	) else $error("abnormal speed enable wrong");

	sync_enable_a: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		(set_wr && HWDATA_IN[29]) ##1 !set_wr |-> SYNC_LOSS_LOCK_ENABLE_OUT
	) else $error("sync loss enable lost");

	nomtr_enable_a: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		!set_wr |=> $stable(NO_MOTOR_LOCK_ENABLE_OUT)
	) else $error("no motor enable changed without write");

	abn_thr_map_a: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		ABNORMAL_SPEED_THRESHOLD_HZ_OUT
			== 12'((s_r.settings[27:24] + 12'h1) * 12'd250)
	) else $error("abnormal speed threshold wrong");

	sync_count_map_a: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		SYNC_LOSS_COUNT_OUT == {1'b0, s_r.settings[23:21]} + 4'h2
	) else $error("sync loss count wrong");

	nomtr_thr_map_a: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		NO_MOTOR_CURRENT_THRESHOLD_100UV_OUT == (
			(s_r.settings[`MFC_NOMTR_THR_F] == 3'h0) ? 9'd50 :
			(s_r.settings[`MFC_NOMTR_THR_F] == 3'h1) ? 9'd75 :
			(s_r.settings[`MFC_NOMTR_THR_F] == 3'h2) ? 9'd100 :
			(s_r.settings[`MFC_NOMTR_THR_F] == 3'h3) ? 9'd125 :
			(s_r.settings[`MFC_NOMTR_THR_F] == 3'h4) ? 9'd200 :
			(s_r.settings[`MFC_NOMTR_THR_F] == 3'h5) ? 9'd250 :
			(s_r.settings[`MFC_NOMTR_THR_F] == 3'h6) ? 9'd300 :
			9'd400)
	) else $error("no motor threshold wrong");

	ov_mode_a: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		set_wr |=> OVERVOLTAGE_CLEAR_MODE_OUT == $past(HWDATA_IN[17])
	) else $error("overvoltage mode wrong");

	upper_nolimit_a: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		SUPPLY_UPPER_LIMIT_V_OUT == (
			(s_r.settings[`MFC_UPPER_F] == 3'h0) ? 6'd0 :
			(s_r.settings[`MFC_UPPER_F] == 3'h1) ? 6'd20 :
			(s_r.settings[`MFC_UPPER_F] == 3'h2) ? 6'd25 :
			(s_r.settings[`MFC_UPPER_F] == 3'h3) ? 6'd30 :
			(s_r.settings[`MFC_UPPER_F] == 3'h4) ? 6'd35 :
			(s_r.settings[`MFC_UPPER_F] == 3'h5) ? 6'd40 :
			(s_r.settings[`MFC_UPPER_F] == 3'h6) ? 6'd50 :
			6'd60)
	) else $error("upper limit wrong");

	uv_mode_a: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		set_wr |=> UNDERVOLTAGE_CLEAR_MODE_OUT == $past(HWDATA_IN[13])
	) else $error("undervoltage mode wrong");

	lower_top_a: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		SUPPLY_LOWER_LIMIT_V_OUT == (
			(s_r.settings[`MFC_LOWER_F] == 3'h0) ? 4'd0 :
			(s_r.settings[`MFC_LOWER_F] == 3'h1) ? 4'd6 :
			(s_r.settings[`MFC_LOWER_F] == 3'h2) ? 4'd7 :
			(s_r.settings[`MFC_LOWER_F] == 3'h3) ? 4'd8 :
			(s_r.settings[`MFC_LOWER_F] == 3'h4) ? 4'd9 :
			(s_r.settings[`MFC_LOWER_F] == 3'h5) ? 4'd10 :
			(s_r.settings[`MFC_LOWER_F] == 3'h6) ? 4'd12 :
			4'd15)
	) else $error("lower limit wrong");

	retry_map_a: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		RETRY_LIMIT_OUT == (
			(s_r.settings[`MFC_RETRY_F] == 3'h0) ? 5'd0 :
			(s_r.settings[`MFC_RETRY_F] == 3'h1) ? 5'd2 :
			(s_r.settings[`MFC_RETRY_F] == 3'h2) ? 5'd3 :
			(s_r.settings[`MFC_RETRY_F] == 3'h3) ? 5'd5 :
			(s_r.settings[`MFC_RETRY_F] == 3'h4) ? 5'd7 :
			(s_r.settings[`MFC_RETRY_F] == 3'h5) ? 5'd10 :
			(s_r.settings[`MFC_RETRY_F] == 3'h6) ? 5'd15 :
			5'd20)
	) else $error("retry limit wrong");

	floor_map_a: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		LOCK_FLOOR_SPEED_HALF_HZ_OUT == (
			(s_r.settings[`MFC_FLOOR_F] == 3'h0) ? 6'd1 :
			(s_r.settings[`MFC_FLOOR_F] == 3'h1) ? 6'd2 :
			(s_r.settings[`MFC_FLOOR_F] == 3'h2) ? 6'd4 :
			(s_r.settings[`MFC_FLOOR_F] == 3'h3) ? 6'd6 :
			(s_r.settings[`MFC_FLOOR_F] == 3'h4) ? 6'd10 :
			(s_r.settings[`MFC_FLOOR_F] == 3'h5) ? 6'd20 :
			(s_r.settings[`MFC_FLOOR_F] == 3'h6) ? 6'd30 :
			6'd50)
	) else $error("floor speed wrong");

	jump_ratio_a: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		SPEED_JUMP_RATIO_OUT == {1'b0, s_r.settings[3:2], 1'b0} + 4'h2
	) else $error("speed jump ratio wrong");

	zero_duty_a: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		ZERO_SPEED_DUTY_THRESHOLD_PERMIL_OUT
			== 5'd10 + 5'(s_r.settings[1:0] * 5'd5)
	) else $error("zero duty threshold wrong");

	readback_a: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		set_wr ##1 (addr_take && !HWRITE_IN && HADDR_IN[7:0] == 8'h94)
			|=> HRDATA_OUT == $past(HWDATA_IN, 2)
	) else $error("settings readback wrong");

	irq_level_a: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		(set_wr && s_r.irq_mask[`MFC_EV_CFG]) |=> IRQ_OUT
	) else $error("interrupt level wrong");

	// an unmapped read in the same cycle may set its flag again
	stat_clear_a: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		(s_r.dph_wr && (s_r.dph_addr == `MFC_IRQ_STAT_ADDR) && !ev[`MFC_EV_BAD])
			|=> (s_r.irq_stat & $past(HWDATA_IN[`MFC_NEV-1:0])) == '0
	) else $error("status clear lost");

	bad_flag_a: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		(addr_take && !HWRITE_IN && !is_mapped(HADDR_IN[`MFC_ADDR_F]))
			|=> s_r.irq_stat[`MFC_EV_BAD]
	) else $error("unmapped read not flagged");

	// read data stands for its data phase only
	rdata_idle_a: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		!(addr_take && !HWRITE_IN) |=> HRDATA_OUT == 32'h0
	) else $error("read data outside data phase");

	mask_write_a: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		(s_r.dph_wr && (s_r.dph_addr == `MFC_IRQ_MASK_ADDR))
			|=> s_r.irq_mask == $past(HWDATA_IN[`MFC_NEV-1:0])
	) else $error("mask write wrong");

	bad_write_a: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		(s_r.dph_wr && !is_mapped(s_r.dph_addr)) |=> $stable(s_r.settings)
	) else $error("unmapped write changed settings");

	cfg_write_c: cover property (
		@(posedge CLK_IN) disable iff (RST_IN) set_wr
	);

	irq_raise_c: cover property (
		@(posedge CLK_IN) disable iff (RST_IN) $rose(IRQ_OUT)
	);

	bad_addr_c: cover property (
		@(posedge CLK_IN) disable iff (RST_IN) ev[`MFC_EV_BAD]
	);

	readback_c: cover property (
		@(posedge CLK_IN) disable iff (RST_IN) set_wr ##1 (addr_take && !HWRITE_IN)
	);

	irq_clear_c: cover property (
		@(posedge CLK_IN) disable iff (RST_IN) $fell(IRQ_OUT)
	);
endmodule // mfc_bank
`default_nettype wire

//--- dv/tb_top.sv
// bench for the fault settings bank: ahb-lite access, decoded fields, interrupt
// assumes hready is the slave's own hreadyout; the master waits at most 50 cycles for it, then fails
`timescale 1ns/1ps
`default_nettype none
`include "mfc_regs.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb_top;
	logic        clk;
	logic        rst;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        irq;
	logic        parity;
	logic        en_abn;
	logic        en_sync;
	logic        en_nomtr;
	logic [11:0] abn_hz;
	logic [3:0]  sync_cnt;
	logic [8:0]  nomtr;
	logic        ov_mode;
	logic [5:0]  upper;
	logic        uv_mode;
	logic [3:0]  lower;
	logic [4:0]  retry;
	logic [5:0]  floor;
	logic [3:0]  jump;
	logic [4:0]  duty;
	logic [31:0] rd;
	logic [31:0] w;
	logic [3:0]  c;
	int          errors;
	int          tests_run;
	int          nomtr_t [8] = '{50, 75, 100, 125, 200, 250, 300, 400};
	int          upper_t [8] = '{0, 20, 25, 30, 35, 40, 50, 60};
	int          lower_t [8] = '{0, 6, 7, 8, 9, 10, 12, 15};
	int          retry_t [8] = '{0, 2, 3, 5, 7, 10, 15, 20};
	int          floor_t [8] = '{1, 2, 4, 6, 10, 20, 30, 50};

	mfc_bank DUT (
		.CLK_IN                               (clk),
		.RST_IN                               (rst),
		.HSEL_IN                              (hsel),
		.HADDR_IN                             (haddr),
		.HTRANS_IN                            (htrans),
		.HWRITE_IN                            (hwrite),
		.HSIZE_IN                             (3'h2),
		.HREADY_IN                            (hreadyout),
		.HWDATA_IN                            (hwdata),
		.HRDATA_OUT                           (hrdata),
		.HREADYOUT_OUT                        (hreadyout),
		.HRESP_OUT                            (hresp),
		.IRQ_OUT                              (irq),
		.PARITY_OUT                           (parity),
		.ABNORMAL_SPEED_LOCK_ENABLE_OUT       (en_abn),
		.SYNC_LOSS_LOCK_ENABLE_OUT            (en_sync),
		.NO_MOTOR_LOCK_ENABLE_OUT             (en_nomtr),
		.ABNORMAL_SPEED_THRESHOLD_HZ_OUT      (abn_hz),
		.SYNC_LOSS_COUNT_OUT                  (sync_cnt),
		.NO_MOTOR_CURRENT_THRESHOLD_100UV_OUT (nomtr),
		.OVERVOLTAGE_CLEAR_MODE_OUT           (ov_mode),
		.SUPPLY_UPPER_LIMIT_V_OUT             (upper),
		.UNDERVOLTAGE_CLEAR_MODE_OUT          (uv_mode),
		.SUPPLY_LOWER_LIMIT_V_OUT             (lower),
		.RETRY_LIMIT_OUT                      (retry),
		.LOCK_FLOOR_SPEED_HALF_HZ_OUT         (floor),
		.SPEED_JUMP_RATIO_OUT                 (jump),
		.ZERO_SPEED_DUTY_THRESHOLD_PERMIL_OUT (duty)
	);

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task give_verdict;
	begin
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	end
	endtask

	// outputs are read at the edge itself, before that edge's updates land
	task automatic wait_ready;
		int n;
	begin
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1)
		begin
			errors++;
			$display("[FAIL] hready expected 1 seen %h", hreadyout);
			give_verdict;
		end
	end
	endtask

	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
	begin
		// called just after an edge, so a read can follow a write at once
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h00_0000, a};
		hwrite <= wr;
		wait_ready;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready;
		rd = hrdata;
		`CHK("hresp", 1'b0, hresp)
	end
	endtask

	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
	begin
		xfer(1'b0, a, ~e);
		`CHK(nm, e, rd)
	end
	endtask

	task chk_zero;
	begin
		`CHK("irq", 1'b0, irq)
		`CHK("parity", 1'b0, parity)
		`CHK("en_abn", 1'b0, en_abn)
		`CHK("en_sync", 1'b0, en_sync)
		`CHK("en_nomtr", 1'b0, en_nomtr)
		`CHK("abn_hz", 12'h0fa, abn_hz)
		`CHK("sync_cnt", 4'h2, sync_cnt)
		`CHK("nomtr", 9'h032, nomtr)
		`CHK("ov_mode", 1'b0, ov_mode)
		`CHK("upper", 6'h00, upper)
		`CHK("uv_mode", 1'b0, uv_mode)
		`CHK("lower", 4'h0, lower)
		`CHK("retry", 5'h00, retry)
		`CHK("floor", 6'h01, floor)
		`CHK("jump", 4'h2, jump)
		`CHK("duty", 5'h0a, duty)
	end
	endtask

	initial
	begin
		errors = 0;
		tests_run = 0;
		rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0000_0000;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk_zero;
		rchk("settings", `MFC_SETTINGS_ADDR, 32'h0000_0000);
		rchk("status", `MFC_IRQ_STAT_ADDR, 32'h0000_0000);
		// every code of every field, all fields moving at once
		for (int i = 0; i < 16; i++)
		begin
			c = 4'(i);
			w = {~c[1], c[0], c[1], c[2], c, c[2:0], c[2:0], c[3], c[2:0], ~c[0],
				c[2:0], c[2:0], c[2:0], c[1:0], c[1:0]};
			xfer(1'b1, `MFC_SETTINGS_ADDR, w);
			rchk("readback", `MFC_SETTINGS_ADDR, w);
			`CHK("parity", ~c[1], parity)
			`CHK("en_abn", c[0], en_abn)
			`CHK("en_sync", c[1], en_sync)
			`CHK("en_nomtr", c[2], en_nomtr)
			`CHK("abn_hz", 12'((i + 1) * 250), abn_hz)
			`CHK("sync_cnt", 4'(i % 8 + 2), sync_cnt)
			`CHK("nomtr", 9'(nomtr_t[i % 8]), nomtr)
			`CHK("ov_mode", c[3], ov_mode)
			`CHK("upper", 6'(upper_t[i % 8]), upper)
			`CHK("uv_mode", ~c[0], uv_mode)
			`CHK("lower", 4'(lower_t[i % 8]), lower)
			`CHK("retry", 5'(retry_t[i % 8]), retry)
			`CHK("floor", 6'(floor_t[i % 8]), floor)
			`CHK("jump", 4'((i % 4 + 1) * 2), jump)
			`CHK("duty", 5'(10 + 5 * (i % 4)), duty)
		end
		// interrupt: masked, unmasked, cleared, unmapped access
		rchk("status", `MFC_IRQ_STAT_ADDR, 32'h0000_0001);
		`CHK("irq masked", 1'b0, irq)
		xfer(1'b1, `MFC_IRQ_MASK_ADDR, 32'hffff_ffff);
		rchk("mask", `MFC_IRQ_MASK_ADDR, 32'h0000_0003);
		`CHK("irq set", 1'b1, irq)
		xfer(1'b1, `MFC_IRQ_STAT_ADDR, 32'h0000_0001);
		rchk("status", `MFC_IRQ_STAT_ADDR, 32'h0000_0000);
		`CHK("irq clear", 1'b0, irq)
		rchk("unmapped", 8'h40, 32'h0000_0000);
		rchk("status", `MFC_IRQ_STAT_ADDR, 32'h0000_0002);
		`CHK("irq unmapped", 1'b1, irq)
		xfer(1'b1, 8'h44, 32'hffff_ffff);
		rchk("settings kept", `MFC_SETTINGS_ADDR, w);
		xfer(1'b1, `MFC_IRQ_STAT_ADDR, 32'h0000_0002);
		xfer(1'b1, `MFC_IRQ_MASK_ADDR, 32'h0000_0001);
		rchk("unmapped", 8'h48, 32'h0000_0000);
		rchk("status", `MFC_IRQ_STAT_ADDR, 32'h0000_0002);
		`CHK("irq bit1 masked", 1'b0, irq)
		// second reset in mid-run clears everything again
		xfer(1'b1, `MFC_SETTINGS_ADDR, 32'hffff_ffff);
		@(posedge clk);
		`CHK("irq cfg", 1'b1, irq)
		rst <= 1'b1;
		@(posedge clk);
		@(posedge clk);
		chk_zero;
		rst <= 1'b0;
		@(posedge clk);
		rchk("settings", `MFC_SETTINGS_ADDR, 32'h0000_0000);
		rchk("mask", `MFC_IRQ_MASK_ADDR, 32'h0000_0000);
		give_verdict;
	end
endmodule // tb_top
`default_nettype wire
